// ---- rtl/ssrx_map.svh ----
// register offsets, field positions and reset values of the receive sequencer
`ifndef SSRX_MAP_SVH
`define SSRX_MAP_SVH
`define SSRX_A_BUF 8'h00
`define SSRX_A_MODE 8'h01
`define SSRX_A_CFG 8'h02
`define SSRX_A_ACC 8'h03
`define SSRX_A_BASE 8'h04
`define SSRX_A_LAST 8'h05
`define SSRX_A_FLAGS 8'h06
`define SSRX_A_COUNT 8'h07
`define SSRX_A_NEXT 8'h08
`define SSRX_A_WIN_HI 8'h09
`define SSRX_A_WIN_LO 8'h0A
`define SSRX_A_PRE_HI 8'h0B
`define SSRX_A_PRE_LO 8'h0C
`define SSRX_A_STATUS 8'h0D
`define SSRX_M_SLEEP 3'h0
`define SSRX_M_STANDBY 3'h1
`define SSRX_M_SYNTH 3'h4
`define SSRX_M_ENDLESS 3'h5
`define SSRX_M_ONE_SHOT 3'h6
`define SSRX_F_WE 7
`define SSRX_F_PR 6
`define SSRX_F_PCF 5
`define SSRX_F_HA 4
`define SSRX_WIN_RST 10'h005
`define SSRX_PRE_RST 16'h0008
`define SSRX_BASE_RST 8'h00
`endif

// ---- rtl/ssrx_pkg.sv ----
// types shared by the receive sequencer files
package ssrx_pkg;
    typedef enum logic [2:0] {
        SSRX_IDLE = 3'h0,
        SSRX_SEARCH = 3'h1,
        SSRX_PREAMBLE = 3'h2,
        SSRX_HEADER = 3'h3,
        SSRX_PAYLOAD = 3'h4
    } ssrx_state_t;

    typedef struct packed {
        logic [2:0] mode;
        logic explicit;
        logic [7:0] acc_ptr;
        logic [7:0] rx_base;
        logic [7:0] last_start;
        logic [7:0] flags;
        logic [7:0] byte_cnt;
        logic [7:0] wptr;
        logic [9:0] win;
        logic [15:0] pre_len;
        logic [15:0] pre_cnt;
        logic [9:0] tmr;
        ssrx_state_t st;
        logic sym_d;
        logic [7:0] clr;
        logic [7:0] rdata;
        logic synth_en;
        logic rf_en;
        logic gain_hold;
    } ssrx_core_t;
endpackage

// ---- rtl/ssrx_sync.sv ----
// two-flop synchroniser for the demodulator pins
`timescale 1ns/10ps
module ssrx_sync #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssrx_sync_t;

    ssrx_sync_t sync;
    ssrx_sync_t next_sync;

    // first stage feeds only the second stage
    always_comb
    begin
        next_sync.s1 = d;
        next_sync.s2 = sync.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sync <= '0;
        else
            sync <= next_sync;
    end

    assign q = sync.s2;
endmodule

// ---- rtl/ssrx_buf.sv ----
// 256-byte data buffer: receive/clear port, host write port, registered read
`timescale 1ns/10ps
module ssrx_buf #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // receive or clear write port
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_data,
    // host write port
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_data,
    // host read port
    input wire logic [AW-1:0] r_addr,
    output logic [DW-1:0] r_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // port a written last so a received byte wins an address clash
    always_ff @(posedge clk)
    begin
        if (b_we)
            mem[b_addr] <= b_data;
        if (a_we)
            mem[a_addr] <= a_data;
    end

    // read data always from a register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r_data <= '0;
        else
            r_data <= mem[r_addr];
    end
endmodule

// ---- rtl/ssrx_core.sv ----
// receive sequencer: listen modes, search window, event flags, buffer pointers
// Contract
// - one-shot: no preamble by window end raises window-expired, goes standby.
// - window length in symbols, 4 to 1023, reset value 5.
// - payload end raises packet-received, plus check-failed on bad check.
// - payload bytes are stored even when the check fails.
// - one-shot: packet-received or window-expired returns to standby.
// - one-shot: synthesizer and RF switched off once a packet is received.
// - after preamble, gain held; explicit header raises header-accepted first.
// - endless: search, track packet, then search again without stopping.
// - endless: too long preamble dropped, search restarts, no flag.
// - endless: timeout raises window-expired, mode kept, host clears flag.
// - endless: bytes stored in order, write pointer never reset.
// - status describes latest packet only; host reads before next one.
// - last-packet-start holds packet start for host extraction.
// - next-write-location reports one past the last received byte.
// - header-accepted also raised in implicit header mode.
// - timeout timer starts on entering either listen mode.
// - timeout equals symbol count times symbol period.
// - each buffer data port access advances the access pointer.
// - sleep clears the buffer and blocks access; other modes keep it.
// - receive base resets to 0x00; long packets run into transmit area.
// - explicit header: byte count loaded from header length.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "ssrx_map.svh"
module ssrx_core (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // demodulator pins, asynchronous
    input wire logic DEMOD_SYM_CLK,
    input wire logic DEMOD_PREAMBLE,
    input wire logic DEMOD_HEADER,
    input wire logic DEMOD_BYTE,
    input wire logic DEMOD_END,
    input wire logic DEMOD_CHECK_OK,
    input wire logic [7:0] DEMOD_DATA,
    // front-end control
    output logic SYNTH_EN,
    output logic RF_EN,
    output logic GAIN_HOLD
);
    ssrx_pkg::ssrx_core_t core;
    ssrx_pkg::ssrx_core_t next_core;
    logic [13:0] pins;
    logic sym;
    logic pre;
    logic hdr;
    logic byte_in;
    logic pend;
    logic ok;
    logic [7:0] din;
    logic sym_edge;
    logic mode_wr;
    logic a_we;
    logic [7:0] a_addr;
    logic [7:0] a_data;
    logic b_we;
    logic [7:0] mem_q;

    // true for the two listen modes
    function automatic logic ssrx_listen(input logic [2:0] m);
        return (m == `SSRX_M_ONE_SHOT) || (m == `SSRX_M_ENDLESS);
    endfunction

    // register read decode, buffer port handled apart
    function automatic logic [7:0] ssrx_reg_read(input logic [7:0] a,
                                                 input ssrx_pkg::ssrx_core_t c);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            `SSRX_A_MODE: r = {5'h00, c.mode};
            `SSRX_A_CFG: r = {7'h00, c.explicit};
            `SSRX_A_ACC: r = c.acc_ptr;
            `SSRX_A_BASE: r = c.rx_base;
            `SSRX_A_LAST: r = c.last_start;
            `SSRX_A_FLAGS: r = c.flags;
            `SSRX_A_COUNT: r = c.byte_cnt;
            `SSRX_A_NEXT: r = c.wptr;
            `SSRX_A_WIN_HI: r = {6'h00, c.win[9:8]};
            `SSRX_A_WIN_LO: r = c.win[7:0];
            `SSRX_A_PRE_HI: r = c.pre_len[15:8];
            `SSRX_A_PRE_LO: r = c.pre_len[7:0];
            `SSRX_A_STATUS: r = {5'h00, c.st};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // every demodulator pin passes two flops before use
    ssrx_sync #(
        .W(14)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d({DEMOD_SYM_CLK, DEMOD_PREAMBLE, DEMOD_HEADER, DEMOD_BYTE,
            DEMOD_END, DEMOD_CHECK_OK, DEMOD_DATA}),
        .q(pins)
    );

    assign {sym, pre, hdr, byte_in, pend, ok, din} = pins;
    // data change on the falling symbol edge, so the rising edge sees them settled
    assign sym_edge = sym && !core.sym_d;
    assign mode_wr = WR && (ADDR == `SSRX_A_MODE);

    // shared data buffer
    ssrx_buf #(
        .AW(8),
        .DW(8)
    ) u_buf (
        .clk(CORE_CLK),
        .rst(RST),
        .a_we(a_we),
        .a_addr(a_addr),
        .a_data(a_data),
        .b_we(b_we),
        .b_addr(core.acc_ptr),
        .b_data(WDATA),
        .r_addr(next_core.acc_ptr),
        .r_data(mem_q)
    );

    // next state: host access first, then receive events so a set beats a clear
    always_comb
    begin
        next_core = core;
        next_core.sym_d = sym;
        a_we = 1'b0;
        a_addr = core.wptr;
        a_data = din;
        b_we = 1'b0;
        // host writes
        if (WR)
        begin
            case (ADDR)
                `SSRX_A_BUF:
                begin
                    if (core.mode != `SSRX_M_SLEEP)
                    begin
                        b_we = 1'b1;
                        next_core.acc_ptr = core.acc_ptr + 8'h01;
                    end
                end
                `SSRX_A_MODE:
                begin
                    next_core.mode = WDATA[2:0];
                    if (ssrx_listen(WDATA[2:0]) && (WDATA[2:0] != core.mode))
                    begin
                        // timer is absolute from entry; write pointer set once here
                        next_core.st = ssrx_pkg::SSRX_SEARCH;
                        next_core.tmr = 10'h000;
                        next_core.wptr = core.rx_base;
                    end
                    else if (!ssrx_listen(WDATA[2:0]))
                        next_core.st = ssrx_pkg::SSRX_IDLE;
                end
                `SSRX_A_CFG: next_core.explicit = WDATA[0];
                `SSRX_A_ACC: next_core.acc_ptr = WDATA;
                `SSRX_A_BASE: next_core.rx_base = WDATA;
                `SSRX_A_FLAGS: next_core.flags = core.flags & ~WDATA;
                `SSRX_A_WIN_HI: next_core.win[9:8] = WDATA[1:0];
                `SSRX_A_WIN_LO: next_core.win[7:0] = WDATA;
                `SSRX_A_PRE_HI: next_core.pre_len[15:8] = WDATA;
                `SSRX_A_PRE_LO: next_core.pre_len[7:0] = WDATA;
                default: ;
            endcase
        end
        // host reads, data stand in the next cycle
        if (RD)
        begin
            if (ADDR == `SSRX_A_BUF)
            begin
                if (core.mode != `SSRX_M_SLEEP)
                begin
                    next_core.rdata = mem_q;
                    next_core.acc_ptr = core.acc_ptr + 8'h01;
                end
                else
                    next_core.rdata = 8'h00;
            end
            else
                next_core.rdata = ssrx_reg_read(ADDR, core);
        end
        // receive sequencing, one step per symbol; a mode write this cycle wins
        if (sym_edge && !mode_wr)
        begin
            case (core.st)
                ssrx_pkg::SSRX_SEARCH:
                begin
                    if (pre)
                    begin
                        next_core.st = ssrx_pkg::SSRX_PREAMBLE;
                        next_core.pre_cnt = 16'h0001;
                    end
                    else if ({6'h00, core.tmr} + 16'h0001 >= {6'h00, core.win})
                    begin
                        next_core.flags[`SSRX_F_WE] = 1'b1;
                        next_core.tmr = 10'h000;
                        if (core.mode == `SSRX_M_ONE_SHOT)
                        begin
                            next_core.mode = `SSRX_M_STANDBY;
                            next_core.st = ssrx_pkg::SSRX_IDLE;
                        end
                        // endless mode stays and keeps searching
                    end
                    else
                        next_core.tmr = core.tmr + 10'h001;
                end
                ssrx_pkg::SSRX_PREAMBLE:
                begin
                    if (pre)
                    begin
                        if ((core.mode == `SSRX_M_ENDLESS) && (core.pre_cnt >= core.pre_len))
                        begin
                            next_core.st = ssrx_pkg::SSRX_SEARCH;
                            next_core.tmr = 10'h000;
                        end
                        else
                            next_core.pre_cnt = core.pre_cnt + 16'h0001;
                    end
                    else
                    begin
                        // end of preamble: lock gain and mark packet start
                        next_core.last_start = core.wptr;
                        next_core.byte_cnt = 8'h00;
                        if (core.explicit)
                            next_core.st = ssrx_pkg::SSRX_HEADER;
                        else
                        begin
                            next_core.flags[`SSRX_F_HA] = 1'b1;
                            next_core.st = ssrx_pkg::SSRX_PAYLOAD;
                        end
                    end
                end
                ssrx_pkg::SSRX_HEADER:
                begin
                    if (hdr)
                    begin
                        next_core.flags[`SSRX_F_HA] = 1'b1;
                        next_core.byte_cnt = din;
                        next_core.st = ssrx_pkg::SSRX_PAYLOAD;
                    end
                end
                ssrx_pkg::SSRX_PAYLOAD:
                begin
                    if (byte_in)
                    begin
                        // stored whatever the check says; wraps into transmit area
                        a_we = 1'b1;
                        next_core.wptr = core.wptr + 8'h01;
                        if (!core.explicit)
                            next_core.byte_cnt = core.byte_cnt + 8'h01;
                    end
                    if (pend)
                    begin
                        next_core.flags[`SSRX_F_PR] = 1'b1;
                        if (!ok)
                            next_core.flags[`SSRX_F_PCF] = 1'b1;
                        if (core.mode == `SSRX_M_ONE_SHOT)
                        begin
                            next_core.mode = `SSRX_M_STANDBY;
                            next_core.st = ssrx_pkg::SSRX_IDLE;
                        end
                        else
                        begin
                            next_core.st = ssrx_pkg::SSRX_SEARCH;
                            next_core.tmr = 10'h000;
                        end
                    end
                end
                default: ;
            endcase
        end
        // sleep sweeps the buffer to zero, one location per cycle
        if (core.mode == `SSRX_M_SLEEP)
        begin
            a_we = 1'b1;
            a_addr = core.clr;
            a_data = 8'h00;
            next_core.clr = core.clr + 8'h01;
        end
        else
            next_core.clr = 8'h00;
        // front-end enables follow the next mode, so they drop with the packet
        next_core.rf_en = ssrx_listen(next_core.mode);
        next_core.synth_en = next_core.rf_en || (next_core.mode == `SSRX_M_SYNTH);
        next_core.gain_hold = (next_core.st == ssrx_pkg::SSRX_HEADER) ||
                              (next_core.st == ssrx_pkg::SSRX_PAYLOAD);
    end

    // state register
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            core <= '0;
            core.mode <= `SSRX_M_STANDBY;
            core.explicit <= 1'b1;
            core.rx_base <= `SSRX_BASE_RST;
            core.win <= `SSRX_WIN_RST;
            core.pre_len <= `SSRX_PRE_RST;
            core.st <= ssrx_pkg::SSRX_IDLE;
        end
        else
            core <= next_core;
    end

    assign RDATA = core.rdata;
    assign SYNTH_EN = core.synth_en;
    assign RF_EN = core.rf_en;
    assign GAIN_HOLD = core.gain_hold;

    // checks on the sequencer
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    property p_one_shot_expire;
        $rose(core.flags[`SSRX_F_WE]) && ($past(core.mode) == `SSRX_M_ONE_SHOT)
            && !$past(mode_wr) |-> (core.mode == `SSRX_M_STANDBY) && !RF_EN;
    endproperty
    a_one_shot_expire: assert property (p_one_shot_expire)
        else $error("one-shot window expiry did not return to standby");

    property p_window_count;
        $rose(core.flags[`SSRX_F_WE]) |-> ({6'h00, $past(core.tmr)} + 16'h0001)
            >= {6'h00, $past(core.win)};
    endproperty
    a_window_count: assert property (p_window_count)
        else $error("window expired before the programmed symbol count");

    property p_check_fail;
        $rose(core.flags[`SSRX_F_PR]) && !$past(ok) |-> core.flags[`SSRX_F_PCF];
    endproperty
    a_check_fail: assert property (p_check_fail)
        else $error("bad payload check not flagged with packet received");

    property p_front_end_off;
        $rose(core.flags[`SSRX_F_PR]) && ($past(core.mode) == `SSRX_M_ONE_SHOT)
            && !$past(mode_wr) |-> !RF_EN && !SYNTH_EN;
    endproperty
    a_front_end_off: assert property (p_front_end_off)
        else $error("front end still on after one-shot packet");

    property p_gain_held;
        (core.st == ssrx_pkg::SSRX_PAYLOAD) |-> GAIN_HOLD;
    endproperty
    a_gain_held: assert property (p_gain_held)
        else $error("gain not held during payload");

    property p_endless_stays;
        (core.mode == `SSRX_M_ENDLESS) && !mode_wr ##1 $rose(core.flags[`SSRX_F_WE])
            |-> core.mode == `SSRX_M_ENDLESS;
    endproperty
    a_endless_stays: assert property (p_endless_stays)
        else $error("endless mode left on timeout");

    property p_wptr_steps;
        (core.mode == `SSRX_M_ENDLESS) && !mode_wr |=>
            (core.wptr == $past(core.wptr)) || (core.wptr == $past(core.wptr) + 8'h01);
    endproperty
    a_wptr_steps: assert property (p_wptr_steps)
        else $error("write pointer jumped in endless mode");

    property p_next_read;
        RD && (ADDR == `SSRX_A_NEXT) |=> RDATA == $past(core.wptr);
    endproperty
    a_next_read: assert property (p_next_read)
        else $error("next write location read back wrong");

    property p_ptr_advance;
        (WR || RD) && (ADDR == `SSRX_A_BUF) && (core.mode != `SSRX_M_SLEEP)
            |=> core.acc_ptr == $past(core.acc_ptr) + 8'h01;
    endproperty
    a_ptr_advance: assert property (p_ptr_advance)
        else $error("access pointer did not advance");

    property p_flag_sticky;
        $past(core.flags[`SSRX_F_PR]) && !$past(WR && (ADDR == `SSRX_A_FLAGS))
            |-> core.flags[`SSRX_F_PR];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("packet flag dropped without a clear");

    c_header_seen: cover property ($rose(core.flags[`SSRX_F_HA]));
    c_endless_packet: cover property ((core.mode == `SSRX_M_ENDLESS)
        && $rose(core.flags[`SSRX_F_PR]));
    c_one_shot_timeout: cover property ($rose(core.flags[`SSRX_F_WE])
        && (core.mode == `SSRX_M_STANDBY));
endmodule

// ---- dv/ssrx_demod_model.sv ----
// demodulator stand-in: symbol clock runs only while a symbol is sent
`timescale 1ns/10ps
module ssrx_demod_model (
    // demodulator pins
    output logic sym_clk,
    output logic pre,
    output logic hdr,
    output logic byt,
    output logic fin,
    output logic ok,
    output logic [7:0] data
);
    logic [7:0] q[$];

    // quiet pins at time zero
    initial
    begin
        {sym_clk, pre, hdr, byt, fin, ok} = 6'h00;
        data = 8'h5A;
    end

    // one symbol, levels change while the clock is low; f = {pre, hdr, byte, end, ok}
    task automatic sym(input logic [4:0] f, input logic [7:0] d);
        {pre, hdr, byt, fin, ok} <= f;
        data <= (f[3] | f[2]) ? d : ~data; // released bus must not look like the last byte
        #400 sym_clk <= 1'h1;
        #400 sym_clk <= 1'h0;
    endtask

    // preamble, its end, optional header with length, bytes from q, end mark
    task automatic frame(input int npre, input logic expl, input logic good);
        int n;
        n = q.size();
        repeat (npre) sym(5'h10, 8'h00);
        sym(5'h00, 8'h00);
        if (expl) sym(5'h08, n[7:0]);
        while (q.size() > 0) sym(5'h04, q.pop_front());
        sym({4'h1, good}, 8'h00);
    endtask
endmodule

// ---- dv/spread_spectrum_rx_sequencer_tb.sv ----
// self-checking bench of the receive sequencer against a queue-based model
`timescale 1ns/10ps
`include "ssrx_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module spread_spectrum_rx_sequencer_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] addr, wdata, rdata, dd, rv;
    logic wr, rd, sclk, pre, hdr, byt, fin, ok, synth, rf, gain;
    logic [31:0] seed = 32'hD3D3826C;
    logic [7:0] mem [256];
    int wp, miscompares, compares;

    // 10 MHz clock
    always #50 clk = ~clk;

    ssrx_core DUT (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .DEMOD_SYM_CLK(sclk), .DEMOD_PREAMBLE(pre),
        .DEMOD_HEADER(hdr), .DEMOD_BYTE(byt), .DEMOD_END(fin), .DEMOD_CHECK_OK(ok),
        .DEMOD_DATA(dd), .SYNTH_EN(synth), .RF_EN(rf), .GAIN_HOLD(gain));
    ssrx_demod_model dem (.sym_clk(sclk), .pre(pre), .hdr(hdr), .byt(byt), .fin(fin),
        .ok(ok), .data(dd));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // one-cycle write strobe
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    // read: data stands from the cycle after the strobe until the next read
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 rv = rdata;
        `CHK(rv, e)
    endtask

    // random payload into the demodulator and into the expected buffer image
    task automatic push_bytes(input int n);
        repeat (n)
        begin
            seed = lfsr(seed);
            dem.q.push_back(seed[7:0]);
            mem[wp] = seed[7:0];
            wp = (wp + 1) % 256;
        end
    endtask

    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a hang costs a mismatch; the whole run needs well under 2 ms
    initial
    begin
        #2000000;
        miscompares++;
        results();
    end

    initial
    begin
        {wr, rd, addr, wdata} = 18'h0;
        miscompares = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        chk(`SSRX_A_WIN_LO, 8'h05);
        chk(`SSRX_A_WIN_HI, 8'h00);
        chk(`SSRX_A_BASE, 8'h00);
        chk(`SSRX_A_MODE, 8'h01);
        chk(8'hF0, 8'h00);
        $display("test reset done");
        // smallest window: no flag after three idle symbols, flag at the fourth
        wrr(`SSRX_A_WIN_LO, 8'h04);
        wrr(`SSRX_A_MODE, 8'h06);
        repeat (3) dem.sym(5'h00, 8'h00);
        repeat (8) @(posedge clk);
        chk(`SSRX_A_FLAGS, 8'h00);
        `CHK({synth, rf, gain}, 3'h6)
        dem.sym(5'h00, 8'h00);
        repeat (8) @(posedge clk);
        chk(`SSRX_A_FLAGS, 8'h80);
        chk(`SSRX_A_MODE, 8'h01);
        chk(`SSRX_A_FLAGS, 8'h80);
        wrr(`SSRX_A_FLAGS, 8'h80);
        chk(`SSRX_A_FLAGS, 8'h00);
        $display("test one-shot timeout done");
        // explicit header with bad check, then implicit with good check; base wraps
        for (int i = 0; i < 2; i++)
        begin
            wrr(`SSRX_A_BASE, 8'hFE);
            wrr(`SSRX_A_ACC, 8'hFE);
            wrr(`SSRX_A_CFG, (i == 0) ? 8'h01 : 8'h00);
            wrr(`SSRX_A_MODE, 8'h06);
            wp = 254;
            push_bytes(4);
            dem.frame(3, i == 0, i[0]);
            repeat (8) @(posedge clk);
            chk(`SSRX_A_FLAGS, (i == 0) ? 8'h70 : 8'h50);
            chk(`SSRX_A_COUNT, 8'h04);
            chk(`SSRX_A_LAST, 8'hFE);
            chk(`SSRX_A_NEXT, 8'h02);
            chk(`SSRX_A_MODE, 8'h01);
            `CHK({synth, rf, gain}, 3'h0)
            wrr(`SSRX_A_ACC, 8'hFE);
            for (int j = 0; j < 4; j++) chk(`SSRX_A_BUF, mem[(254 + j) % 256]);
            chk(`SSRX_A_ACC, 8'h02);
            wrr(`SSRX_A_FLAGS, 8'hF0);
        end
        $display("test one-shot packets done");
        // endless: timeout keeps the mode, packets follow one another in the buffer
        wrr(`SSRX_A_CFG, 8'h01);
        wrr(`SSRX_A_MODE, 8'h05);
        wp = 254;
        repeat (4) dem.sym(5'h00, 8'h00);
        repeat (8) @(posedge clk);
        chk(`SSRX_A_FLAGS, 8'h80);
        chk(`SSRX_A_MODE, 8'h05);
        wrr(`SSRX_A_FLAGS, 8'h80);
        // nine preamble symbols against a length of eight: dropped, search again
        repeat (9) dem.sym(5'h10, 8'h00);
        repeat (8) @(posedge clk);
        chk(`SSRX_A_STATUS, 8'h01);
        chk(`SSRX_A_FLAGS, 8'h00);
        // short preamble, then hold in header state to see the gain locked
        dem.sym(5'h10, 8'h00);
        dem.sym(5'h00, 8'h00);
        repeat (8) @(posedge clk);
        chk(`SSRX_A_STATUS, 8'h03);
        `CHK({synth, rf, gain}, 3'h7)
        dem.sym(5'h08, 8'h00);
        dem.sym(5'h03, 8'h00);
        repeat (8) @(posedge clk);
        chk(`SSRX_A_FLAGS, 8'h50);
        `CHK({synth, rf, gain}, 3'h6)
        wrr(`SSRX_A_FLAGS, 8'hF0);
        for (int k = 0; k < 2; k++)
        begin
            push_bytes(3);
            dem.frame(2, 1'h1, 1'h1);
            repeat (8) @(posedge clk);
            chk(`SSRX_A_LAST, (k == 0) ? 8'hFE : 8'h01);
            chk(`SSRX_A_NEXT, (k == 0) ? 8'h01 : 8'h04);
            chk(`SSRX_A_FLAGS, 8'h50);
            chk(`SSRX_A_MODE, 8'h05);
            wrr(`SSRX_A_FLAGS, 8'hF0);
        end
        wrr(`SSRX_A_ACC, 8'hFE);
        for (int j = 0; j < 6; j++) chk(`SSRX_A_BUF, mem[(254 + j) % 256]);
        $display("test endless done");
        // sleep blocks the port, then the sweep leaves the buffer empty
        wrr(`SSRX_A_MODE, 8'h00);
        wrr(`SSRX_A_ACC, 8'h10);
        chk(`SSRX_A_BUF, 8'h00);
        chk(`SSRX_A_ACC, 8'h10);
        repeat (300) @(posedge clk);
        wrr(`SSRX_A_MODE, 8'h01);
        wrr(`SSRX_A_ACC, 8'hFE);
        chk(`SSRX_A_BUF, 8'h00);
        chk(`SSRX_A_ACC, 8'hFF);
        $display("test sleep done");
        results();
    end
endmodule
